// ### neac_checker.sv
// assertions on the sfr link between the cpu end and the device end
`timescale 1ns/1ps
`default_nettype none
`include "neac_consts.svh"
module neac_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // sfr link
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic irq_req,
    input wire logic irq_ack,
    input wire logic stack_full,
    input wire logic cpu_halt
);
    // ==========
    // mirrors of what the cpu wrote
    logic [7:0] bank_m;
    logic [7:0] ptr_m;
    logic en_m;
    logic gie_m;
    logic armed;
    logic [10:0] wcnt;
    logic ctrl_sel;
    logic ctrl_wr;
    assign ctrl_sel = sfr_addr == `NEAC_SFR_PORT && ptr_m == `NEAC_CTRL_PTR
        && bank_m == `NEAC_CTRL_BANK;
    assign ctrl_wr = sfr_wr && ctrl_sel;
    always_ff @(posedge clock) begin
        if (rst) begin
            bank_m <= 8'h00;
            ptr_m <= 8'h00;
        end else if (sfr_wr && sfr_addr == `NEAC_SFR_BANK) begin
            bank_m <= sfr_wdata;
        end else if (sfr_wr && sfr_addr == `NEAC_SFR_PTR) begin
            ptr_m <= sfr_wdata;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            en_m <= 1'b0;
            gie_m <= 1'b0;
        end else if (sfr_wr && sfr_addr == `NEAC_SFR_IRQ) begin
            en_m <= sfr_wdata[`NEAC_IRQ_EN_BIT];
            gie_m <= sfr_wdata[`NEAC_GIE_BIT];
        end else if (irq_ack) begin
            gie_m <= 1'b0;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (ctrl_wr) begin
            armed <= sfr_wdata[`NEAC_WRITE_ENABLE_BIT_BIT];
        end
    end
    // counts from a taken write start; saturates so idle never looks like a cycle end
    always_ff @(posedge clock) begin
        if (rst) begin
            wcnt <= 11'h7FF;
        end else if (ctrl_wr && sfr_wdata[`NEAC_WR_BIT] && sfr_rdata[`NEAC_WRITE_ENABLE_BIT_BIT]) begin
            wcnt <= 11'h001;
        end else if (wcnt != 11'h7FF) begin
            wcnt <= wcnt + 11'h001;
        end
    end
    // ==========
    // properties
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_rd_start;
        ctrl_wr && sfr_wdata[`NEAC_RD_BIT];
    endsequence
    sequence s_rd_done;
        ctrl_sel && !sfr_wr && !sfr_rdata[`NEAC_RD_BIT];
    endsequence
    bank_mirror_a: assert property (sfr_addr == `NEAC_SFR_BANK |-> sfr_rdata == bank_m)
        else $error("bank read differs from last write");
    write_enable_bit_clear_a: assert property (ctrl_sel && !armed |-> !sfr_rdata[`NEAC_WRITE_ENABLE_BIT_BIT])
        else $error("write enable set without a write");
    rd_done_a: assert property (s_rd_start |-> ##[1:8] s_rd_done)
        else $error("read start did not clear");
    rd_order_a: assert property (s_rd_start |-> sfr_rdata[`NEAC_READ_ENABLE_BIT_BIT])
        else $error("read start before read enable");
    wr_order_a: assert property (ctrl_wr && sfr_wdata[`NEAC_WR_BIT] |->
        $past(ctrl_wr) && $past(sfr_wdata[`NEAC_WRITE_ENABLE_BIT_BIT])) else $error("write start late");
    wr_end_irq_a: assert property ($rose(irq_req) |-> wcnt >= 11'h63E && wcnt <= 11'h643)
        else $error("irq request not at write end");
    irq_gate_a: assert property (irq_req |-> en_m && gie_m && !stack_full)
        else $error("irq request while masked");
    ctrl_path_a: assert property (sfr_wr && sfr_addr == `NEAC_SFR_PORT |->
        ptr_m == `NEAC_CTRL_PTR && bank_m == `NEAC_CTRL_BANK) else $error("port written early");
endmodule
`default_nettype wire

// ### neac_consts.svh
// constants for the data nv memory access block
`ifndef NEAC_CONSTS_SVH
`define NEAC_CONSTS_SVH
// ==========================
// sfr addresses and values
`define NEAC_ADDR_W 8
`define NEAC_SFR_ADDR 8'h00
`define NEAC_SFR_DATA 8'h01
`define NEAC_SFR_BANK 8'h02
`define NEAC_SFR_PTR 8'h03
`define NEAC_SFR_PORT 8'h04
`define NEAC_SFR_IRQ 8'h05
`define NEAC_CTRL_PTR 8'h40
`define NEAC_CTRL_BANK 8'h01
// ==========================
// control bit positions
`define NEAC_RD_BIT 0
`define NEAC_READ_ENABLE_BIT_BIT 1
`define NEAC_WR_BIT 2
`define NEAC_WRITE_ENABLE_BIT_BIT 3
// irq register bit positions
`define NEAC_IRQ_EN_BIT 0
`define NEAC_IRQ_FLAG_BIT 1
`define NEAC_GIE_BIT 2
// ==========================
// sizes and timing
`define NEAC_DEPTH 64
`define NEAC_READ_CYCLES 16'h0002
// 16 us at 100 MHz, spelled out so no 8-bit product can wrap
`define NEAC_WRITE_CYCLES 16'h0640
`endif

// ### neac_cpu.sv
// cpu-side sequencer driving the nv memory access sfrs
`timescale 1ns/1ps
`default_nettype none
`include "neac_consts.svh"
module neac_cpu
    import neac_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // user command
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [5:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    output logic done,
    output logic [7:0] rd_data,
    // cpu context
    input wire logic stack_full_in,
    input wire logic halt_req,
    // device side
    neac_if.cpu bus
);
    // ==========================
    // script step counter: at most one sfr write per step
    logic [3:0] step;
    logic wr_op, active;
    logic [5:0] a;
    logic [7:0] d;

    assign cmd_ready = !active;
    assign bus.stack_full = stack_full_in;
    // halt is held off while an operation runs
    assign bus.cpu_halt = halt_req && !active;
    assign bus.irq_ack = 1'b0;

    always_ff @(posedge clock) begin
        if (rst) begin
            active <= 1'b0;
            step <= 4'h0;
            wr_op <= 1'b0;
            a <= 6'h00;
            d <= 8'h00;
            done <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            done <= 1'b0;
            if (!active) begin
                if (cmd_valid) begin
                    active <= 1'b1;
                    step <= 4'h0;
                    wr_op <= cmd_write;
                    a <= cmd_addr;
                    d <= cmd_data;
                end
            end else if (step == 4'h8) begin
                // poll the start bit until it drops
                if (!bus.sfr_rdata[wr_op ? `NEAC_WR_BIT : `NEAC_RD_BIT])
                    step <= 4'h9;
            end else if (step == 4'h9) begin
                rd_data <= bus.sfr_rdata;
                step <= 4'hA;
            end else if (step == 4'hC) begin
                active <= 1'b0;
                done <= 1'b1;
            end else begin
                step <= step + 4'h1;
            end
        end
    end

    always_comb begin
        bus.sfr_wr = 1'b0;
        bus.sfr_addr = `NEAC_SFR_PORT;
        bus.sfr_wdata = 8'h00;
        if (active) begin
            case (step)
                4'h0: begin bus.sfr_wr = 1'b1; bus.sfr_addr = `NEAC_SFR_ADDR;
                    bus.sfr_wdata = {2'b00, a}; end
                4'h1: begin bus.sfr_wr = wr_op; bus.sfr_addr = `NEAC_SFR_DATA;
                    bus.sfr_wdata = d; end
                4'h2: begin bus.sfr_wr = 1'b1; bus.sfr_addr = `NEAC_SFR_PTR;
                    bus.sfr_wdata = `NEAC_CTRL_PTR; end
                4'h3: begin bus.sfr_wr = 1'b1; bus.sfr_addr = `NEAC_SFR_BANK;
                    bus.sfr_wdata = `NEAC_CTRL_BANK; end
                4'h4: begin bus.sfr_wr = 1'b1; bus.sfr_addr = `NEAC_SFR_IRQ;
                    bus.sfr_wdata = 8'h01; end
                4'h5: begin bus.sfr_wr = 1'b1;
                    bus.sfr_wdata = wr_op ? 8'h08 : 8'h02; end
                4'h6: begin bus.sfr_wr = 1'b1;
                    bus.sfr_wdata = wr_op ? 8'h0C : 8'h03; end
                4'h7: begin bus.sfr_wr = 1'b1; bus.sfr_addr = `NEAC_SFR_IRQ;
                    bus.sfr_wdata = 8'h05; end
                4'h9: begin bus.sfr_addr = `NEAC_SFR_DATA; end
                4'hA: begin bus.sfr_wr = 1'b1; end
                4'hB: begin bus.sfr_wr = 1'b1; bus.sfr_addr = `NEAC_SFR_BANK; end
                default: begin
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### neac_dev.sv
// nv data memory access control, device end
`timescale 1ns/1ps
`default_nettype none
`include "neac_consts.svh"
// What this block does
// - power-on clears write enable bit
// - power-on clears bank selector
// - write end sets irq flag always
// - irq needs flag, enables, stack room
// - servicing irq clears flag
// - write start right after write enable
// - software masks global irq around start
// - no halt during an operation
// - reload address for every read
// - control reached via pointer 40h, bank 1
// - read: enable, start, poll bit 0
// - write: enable, start, poll bit 2
// - clear control and bank when done
// - read back written data optionally
// - write start ignored without write enable
// - read end clears start, holds data
// - 64 bytes, 6-bit address
// - never both starts or all four bits
module neac_dev
    import neac_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // cpu side
    neac_if.dev bus,
    // status
    output logic busy,
    output logic op_failed
);
    // ==========================
    // sfr state
    logic [5:0] addr_reg;
    logic [7:0] nv_data_reg;
    logic [7:0] bank_selector;
    logic [7:0] indirect_pointer;
    logic write_enable_bit, write_start, read_enable_bit, read_start;
    logic nv_irq_enable, nv_irq_flag, global_irq_enable;
    logic [7:0] mem [0:`NEAC_DEPTH-1];
    neac_state_t state;
    logic [15:0] timer;
    logic ctrl_sel, ctrl_wr, write_done;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return bus.sfr_wr && (a == b);
    endfunction

    assign ctrl_sel = (indirect_pointer == `NEAC_CTRL_PTR) &&
                      (bank_selector == `NEAC_CTRL_BANK);
    assign ctrl_wr = hit(bus.sfr_addr, `NEAC_SFR_PORT) && ctrl_sel;
    assign busy = (state != NEAC_IDLE);
    assign write_done = (state == NEAC_WRITE) && (timer == 16'h0001);

    // ==========================
    // plain registers
    always_ff @(posedge clock) begin
        if (rst) begin
            addr_reg <= 6'h00;
            bank_selector <= 8'h00;
            indirect_pointer <= 8'h00;
        end else begin
            if (hit(bus.sfr_addr, `NEAC_SFR_ADDR) && !busy)
                addr_reg <= bus.sfr_wdata[5:0];
            if (hit(bus.sfr_addr, `NEAC_SFR_BANK))
                bank_selector <= bus.sfr_wdata;
            if (hit(bus.sfr_addr, `NEAC_SFR_PTR))
                indirect_pointer <= bus.sfr_wdata;
        end
    end

    // ==========================
    // control register and sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            write_enable_bit <= 1'b0;
            read_enable_bit <= 1'b0;
            write_start <= 1'b0;
            read_start <= 1'b0;
            state <= NEAC_IDLE;
            timer <= 16'h0000;
        end else begin
            if (ctrl_wr && !busy) begin
                write_enable_bit <= bus.sfr_wdata[`NEAC_WRITE_ENABLE_BIT_BIT];
                read_enable_bit <= bus.sfr_wdata[`NEAC_READ_ENABLE_BIT_BIT];
                // a start needs its enable already set beforehand
                if (bus.sfr_wdata[`NEAC_WR_BIT] && write_enable_bit) begin
                    write_start <= 1'b1;
                    state <= NEAC_WRITE;
                    timer <= 16'(`NEAC_WRITE_CYCLES);
                end else if (bus.sfr_wdata[`NEAC_RD_BIT] && read_enable_bit) begin
                    read_start <= 1'b1;
                    state <= NEAC_READ;
                    timer <= 16'(`NEAC_READ_CYCLES);
                end
            end else if (ctrl_wr) begin
                // enables may still be dropped while busy
                write_enable_bit <= bus.sfr_wdata[`NEAC_WRITE_ENABLE_BIT_BIT];
                read_enable_bit <= bus.sfr_wdata[`NEAC_READ_ENABLE_BIT_BIT];
            end
            case (state)
                NEAC_READ: begin
                    timer <= timer - 16'h0001;
                    if (timer == 16'h0001) begin
                        read_start <= 1'b0;
                        state <= NEAC_IDLE;
                    end
                end
                NEAC_WRITE: begin
                    timer <= timer - 16'h0001;
                    if (timer == 16'h0001) begin
                        write_start <= 1'b0;
                        state <= NEAC_IDLE;
                    end
                end
                default: begin
                end
            endcase
            if (bus.cpu_halt && busy) begin
                // halting mid-operation aborts it
                read_start <= 1'b0;
                write_start <= 1'b0;
                state <= NEAC_IDLE;
            end
        end
    end

    // ==========================
    // array and data register
    always_ff @(posedge clock) begin
        if (rst) begin
            nv_data_reg <= 8'h00;
            op_failed <= 1'b0;
        end else begin
            if (hit(bus.sfr_addr, `NEAC_SFR_DATA) && !busy)
                nv_data_reg <= bus.sfr_wdata;
            if (state == NEAC_READ && timer == 16'h0001 && !bus.cpu_halt)
                nv_data_reg <= mem[addr_reg];
            if (busy && bus.cpu_halt)
                op_failed <= 1'b1;
            else if (ctrl_wr && !busy)
                op_failed <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (write_done && !bus.cpu_halt)
            mem[addr_reg] <= nv_data_reg;
    end

    // ==========================
    // interrupt
    always_ff @(posedge clock) begin
        if (rst) begin
            nv_irq_enable <= 1'b0;
            nv_irq_flag <= 1'b0;
            global_irq_enable <= 1'b0;
        end else begin
            if (hit(bus.sfr_addr, `NEAC_SFR_IRQ)) begin
                nv_irq_enable <= bus.sfr_wdata[`NEAC_IRQ_EN_BIT];
                global_irq_enable <= bus.sfr_wdata[`NEAC_GIE_BIT];
            end else if (bus.irq_ack) begin
                global_irq_enable <= 1'b0;
            end
            // set beats any clear in the same cycle
            if (write_done && !bus.cpu_halt)
                nv_irq_flag <= 1'b1;
            else if (bus.irq_ack)
                nv_irq_flag <= 1'b0;
            else if (hit(bus.sfr_addr, `NEAC_SFR_IRQ))
                nv_irq_flag <= bus.sfr_wdata[`NEAC_IRQ_FLAG_BIT];
        end
    end

    assign bus.irq_req = nv_irq_flag && nv_irq_enable && global_irq_enable &&
                         !bus.stack_full;

    // ==========================
    // read mux
    always_comb begin
        bus.sfr_rdata = 8'h00;
        if (bus.sfr_addr == `NEAC_SFR_ADDR)
            bus.sfr_rdata = {2'b00, addr_reg};
        else if (bus.sfr_addr == `NEAC_SFR_DATA)
            bus.sfr_rdata = nv_data_reg;
        else if (bus.sfr_addr == `NEAC_SFR_BANK)
            bus.sfr_rdata = bank_selector;
        else if (bus.sfr_addr == `NEAC_SFR_PTR)
            bus.sfr_rdata = indirect_pointer;
        else if (bus.sfr_addr == `NEAC_SFR_PORT && ctrl_sel)
            bus.sfr_rdata = {4'h0, write_enable_bit, write_start, read_enable_bit,
                             read_start};
        else if (bus.sfr_addr == `NEAC_SFR_IRQ)
            bus.sfr_rdata = {5'h00, global_irq_enable, nv_irq_flag, nv_irq_enable};
    end
endmodule
`default_nettype wire

// ### neac_if.sv
// sfr bus between cpu side and nv memory access block
`timescale 1ns/1ps
`default_nettype none
interface neac_if;
    logic sfr_wr;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic irq_req;
    logic irq_ack;
    logic stack_full;
    logic cpu_halt;
    modport dev (input sfr_wr, sfr_addr, sfr_wdata, irq_ack, stack_full, cpu_halt,
                 output sfr_rdata, irq_req);
    modport cpu (output sfr_wr, sfr_addr, sfr_wdata, irq_ack, stack_full, cpu_halt,
                 input sfr_rdata, irq_req);
endinterface
`default_nettype wire

// ### neac_pkg.sv
// types for the data nv memory access block
package neac_pkg;
    typedef enum logic [1:0] {
        NEAC_IDLE = 2'b00,
        NEAC_READ = 2'b01,
        NEAC_WRITE = 2'b10
    } neac_state_t;
endpackage

// ### tb.sv
// self-checking bench for both ends of the nv memory access link
`timescale 1ns/1ps
`default_nettype none
`include "neac_consts.svh"
module tb;
    logic clock, rst, cmd_valid, cmd_write, cmd_ready, done, stack_full_in, halt_req;
    logic busy, op_failed, busy2, failed2;
    logic [5:0] cmd_addr;
    logic [7:0] cmd_data, rd_data, v;
    int err_total, n_checks, i;
    neac_if bus();
    neac_if b2();
    neac_cpu neac_cpu_i (.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .done(done), .rd_data(rd_data),
        .stack_full_in(stack_full_in), .halt_req(halt_req), .bus(bus));
    neac_dev neac_dev_i (.clock(clock), .rst(rst), .bus(bus), .busy(busy),
        .op_failed(op_failed));
    // second device end, driven directly so rule breaks can be made on purpose
    neac_dev neac_dev_i2 (.clock(clock), .rst(rst), .bus(b2), .busy(busy2),
        .op_failed(failed2));
    neac_checker neac_checker_i (.clock(clock), .rst(rst), .sfr_wr(bus.sfr_wr),
        .sfr_addr(bus.sfr_addr), .sfr_wdata(bus.sfr_wdata), .sfr_rdata(bus.sfr_rdata),
        .irq_req(bus.irq_req), .irq_ack(bus.irq_ack), .stack_full(bus.stack_full),
        .cpu_halt(bus.cpu_halt));
    // ==========
    // shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    task automatic cmd(input logic wr, input logic [5:0] a, input logic [7:0] d);
        for (i = 0; i < 3000 && cmd_ready !== 1'b1; i++) tick();
        if (cmd_ready !== 1'b1) begin
            err_total++;
            conclude();
        end
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = a;
        cmd_data = d;
        tick();
        cmd_valid = 1'b0;
        for (i = 0; i < 3000 && done !== 1'b1; i++) tick();
        if (done !== 1'b1) begin
            err_total++;
            conclude();
        end
    endtask
    // strobe stays high across back-to-back writes; a read drops it
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        b2.sfr_wr = 1'b1;
        b2.sfr_addr = a;
        b2.sfr_wdata = d;
        tick();
    endtask
    task automatic r(input logic [7:0] a);
        b2.sfr_wr = 1'b0;
        b2.sfr_addr = a;
        #2 v = b2.sfr_rdata;
        tick();
    endtask
    // ==========
    // scenarios
    task automatic sc_protect();
        r(`NEAC_SFR_BANK);
        chk(v, 8'h00, "bank not cleared");
        w(`NEAC_SFR_PTR, `NEAC_CTRL_PTR);
        w(`NEAC_SFR_PORT, 8'h08);
        w(`NEAC_SFR_BANK, `NEAC_CTRL_BANK);
        r(`NEAC_SFR_PORT);
        chk(v, 8'h00, "control reached from bank 0");
        w(`NEAC_SFR_PORT, 8'h04);
        r(`NEAC_SFR_PORT);
        chk(v, 8'h00, "write start taken without enable");
    endtask
    task automatic sc_roundtrip();
        logic [5:0] ad[3] = '{6'h00, 6'h01, 6'h3F};
        logic [7:0] dt[3] = '{8'hA5, 8'h3C, 8'h5A};
        for (int k = 0; k < 3; k++) cmd(1'b1, ad[k], dt[k]);
        // halt asked between reads must never reach the device mid-operation
        halt_req = 1'b1;
        for (int k = 0; k < 3; k++) begin
            cmd(1'b0, ad[k], 8'h00);
            chk(rd_data, dt[k], "read back differs");
        end
        halt_req = 1'b0;
        chk({7'h00, op_failed}, 8'h00, "operation failed by held-off halt");
        chk({7'h00, busy}, 8'h00, "device still busy after reads");
    endtask
    task automatic sc_write_irq();
        w(`NEAC_SFR_PORT, 8'h08);
        w(`NEAC_SFR_PORT, 8'h0C);
        r(`NEAC_SFR_PORT);
        chk(v & 8'h04, 8'h04, "write start not standing");
        chk({7'h00, busy2}, 8'h01, "write cycle not running");
        for (i = 0; i < 2000 && v[`NEAC_WR_BIT] !== 1'b0; i++) r(`NEAC_SFR_PORT);
        chk(v & 8'h04, 8'h00, "write start never cleared");
        if (v[`NEAC_WR_BIT] !== 1'b0) conclude();
        r(`NEAC_SFR_IRQ);
        chk(v, 8'h02, "flag not set with irq disabled");
        b2.stack_full = 1'b1;
        w(`NEAC_SFR_IRQ, 8'h07);
        r(`NEAC_SFR_IRQ);
        chk({7'h00, b2.irq_req}, 8'h00, "irq with full stack");
        b2.stack_full = 1'b0;
        b2.irq_ack = 1'b1;
        #1 chk({7'h00, b2.irq_req}, 8'h01, "irq not requested");
        tick();
        b2.irq_ack = 1'b0;
        r(`NEAC_SFR_IRQ);
        chk(v & 8'h02, 8'h00, "flag kept after service");
    endtask
    task automatic sc_halt();
        w(`NEAC_SFR_PORT, 8'h08);
        w(`NEAC_SFR_PORT, 8'h0C);
        b2.cpu_halt = 1'b1;
        r(`NEAC_SFR_IRQ);
        chk({7'h00, failed2}, 8'h01, "halt did not fail the write");
        b2.cpu_halt = 1'b0;
        r(`NEAC_SFR_PORT);
        chk(v, 8'h08, "aborted write start still standing");
        chk({7'h00, busy2}, 8'h00, "device busy after abort");
        r(`NEAC_SFR_IRQ);
        chk(v & 8'h02, 8'h00, "flag set by aborted write");
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        {rst, cmd_valid, cmd_write, cmd_addr, cmd_data, stack_full_in, halt_req} = '0;
        {b2.sfr_wr, b2.sfr_addr, b2.sfr_wdata, b2.irq_ack, b2.stack_full, b2.cpu_halt} = '0;
        rst = 1'b1;
        err_total = 0;
        n_checks = 0;
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        sc_protect();
        sc_roundtrip();
        sc_write_irq();
        sc_halt();
        conclude();
    end
endmodule
`default_nettype wire
